// ### core/flash_erase_protect_ctrl.sv
// Purpose: Flash program/erase mode control with protection
// Assumes: CPU side status inputs are on aclk; AXI4-Lite master
// Notes: One write and one read outstanding at most
//
// Implementation choices: the AXI4-Lite register port and the address map.
module flash_erase_protect_ctrl
    import flash_epc_pkg::*;
#(
    parameter int NUM_BLOCKS = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Chip side
    input wire cmode_t chip_mode,
    input wire logic boot_running,
    input wire logic flash_area_read,
    input wire logic exception_start,
    input wire logic sleep_exec,
    // Flash array side
    output logic program_pulse,
    output logic [NUM_BLOCKS-1:0] erase_pulse,
    output logic program_verify,
    output logic erase_verify,
    output logic verify_read_enable,
    output logic irq_disable,
    output pstate_t flash_state
);

    // True when exactly one bit is set
    function automatic logic is_onehot(input logic [NUM_BLOCKS-1:0] v);
        logic [NUM_BLOCKS-1:0] low;
        low = v - {{(NUM_BLOCKS-1){1'b0}}, 1'b1};
        is_onehot = (v != '0) && ((v & low) == '0);
    endfunction : is_onehot

    logic [7:0] flash_ctrl_reg_first;
    logic [NUM_BLOCKS-1:0] erase_block_select_reg;
    logic [7:0] flash_power_ctrl_reg;
    logic [7:0] flash_ctrl_reg_second;
    logic software_write_unlock_bit;
    logic write_check_bit;
    logic erase_check_bit;
    logic flash_low_power_select;
    logic flash_error_flag;
    logic error_event;
    logic hw_protect;
    logic busy;
    logic verify_armed;
    mode_t mode;
    mode_t next_mode;

    // Write channel holding state
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic [7:0] wr_byte;
    logic wr_low;

    // Read channel
    logic [31:0] next_rdata;
    logic next_rok;

    // Field views of the registers
    assign software_write_unlock_bit = flash_ctrl_reg_first[BIT_UNLOCK];
    assign write_check_bit = flash_ctrl_reg_first[BIT_WCHK];
    assign erase_check_bit = flash_ctrl_reg_first[BIT_ECHK];
    assign flash_low_power_select = flash_power_ctrl_reg[BIT_LPSEL];
    assign flash_ctrl_reg_second = {flash_error_flag, 7'h00};

    // Low-power entry acts as hardware protection
    assign hw_protect = (chip_mode == CM_SUBACTIVE) || (chip_mode == CM_SUBSLEEP)
        || (chip_mode == CM_STANDBY);

    assign busy = (mode == MODE_PROG) || (mode == MODE_ERASE);

    // Interrupt masking is combinational so no edge slips through
    assign irq_disable = busy || boot_running;

    // ---- AXI write path ----
    // Each channel is taken on its own; response after both
    assign awready = !aw_held && !bvalid;
    assign wready = !w_held && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end
    end

    // Both halves present: commit the write once
    assign wr_fire = aw_held && w_held;
    assign wr_byte = w_data_q[7:0];
    assign wr_low = w_strb_q[0];

    // Write response; unmapped offsets and the status offset give SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= AXI_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            case (aw_addr_q)
                OFS_CTRL1, OFS_CTRL2, OFS_BLKSEL, OFS_PWR, OFS_VDUMMY: bresp <= AXI_OKAY;
                default: bresp <= AXI_SLVERR;
            endcase
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ---- Registers ----
    // First control register; error leaves it untouched by hardware
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_protect) begin
            flash_ctrl_reg_first <= RST_BYTE;
        end else if (wr_fire && wr_low && aw_addr_q == OFS_CTRL1) begin
            flash_ctrl_reg_first <= wr_byte & CTRL1_MASK;
        end
    end

    // Block select; only the low NUM_BLOCKS bits exist
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_protect) begin
            erase_block_select_reg <= '0;
        end else if (wr_fire && wr_low && aw_addr_q == OFS_BLKSEL) begin
            erase_block_select_reg <= wr_byte[NUM_BLOCKS-1:0];
        end
    end

    // Power select survives low-power entry, else subactive is moot
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_power_ctrl_reg <= RST_BYTE;
        end else if (wr_fire && wr_low && aw_addr_q == OFS_PWR) begin
            flash_power_ctrl_reg <= {wr_byte[BIT_LPSEL], 7'h00};
        end
    end

    // Verify arm: one FF byte in lane 0 at an aligned address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            verify_armed <= 1'b0;
        end else if (mode != MODE_PVER && mode != MODE_EVER) begin
            verify_armed <= 1'b0;
        end else if (wr_fire && aw_addr_q == OFS_VDUMMY && w_strb_q == VDUMMY_STRB
                     && wr_byte == VDUMMY_DATA) begin
            verify_armed <= 1'b1;
        end
    end

    // ---- Mode selection ----
    // Error aborts in the same cycle it is seen; verify stays open
    always_comb begin
        next_mode = MODE_IDLE;
        if (hw_protect || !software_write_unlock_bit) begin
            next_mode = MODE_IDLE;
        end else if (flash_ctrl_reg_first[BIT_PROG] && !flash_error_flag && !error_event) begin
            next_mode = MODE_PROG;
        end else if (flash_ctrl_reg_first[BIT_ERASE] && !flash_error_flag && !error_event) begin
            next_mode = MODE_ERASE;
        end else if (write_check_bit) begin
            next_mode = MODE_PVER;
        end else if (erase_check_bit) begin
            next_mode = MODE_EVER;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode <= MODE_IDLE;
        end else begin
            mode <= next_mode;
        end
    end

    // Flash array strobes follow the mode register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            program_pulse <= 1'b0;
            erase_pulse <= '0;
            program_verify <= 1'b0;
            erase_verify <= 1'b0;
        end else begin
            program_pulse <= next_mode == MODE_PROG;
            program_verify <= next_mode == MODE_PVER;
            erase_verify <= next_mode == MODE_EVER;
            // Multiple selections are refused rather than guessed at
            if (next_mode == MODE_ERASE && is_onehot(erase_block_select_reg)) begin
                erase_pulse <= erase_block_select_reg;
            end else begin
                erase_pulse <= '0;
            end
        end
    end

    assign verify_read_enable = verify_armed;

    // ---- AXI read path ----
    assign arready = !rvalid;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rok = 1'b1;
        case (araddr)
            OFS_CTRL1: next_rdata[7:0] = flash_ctrl_reg_first;
            OFS_CTRL2: next_rdata[7:0] = flash_ctrl_reg_second;
            OFS_BLKSEL: next_rdata[NUM_BLOCKS-1:0] = erase_block_select_reg;
            OFS_PWR: next_rdata[7:0] = flash_power_ctrl_reg;
            OFS_VDUMMY: next_rdata[0] = verify_armed;
            OFS_STATUS: next_rdata[7:0] = {1'b0, irq_disable, verify_armed, flash_state, mode};
            default: next_rok = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= AXI_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rok ? AXI_OKAY : AXI_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ---- Sub-blocks ----
    flash_error_latch u_err (
        .aclk(aclk),
        .aresetn(aresetn),
        .busy(busy),
        .flash_area_read(flash_area_read),
        .exception_start(exception_start),
        .sleep_exec(sleep_exec),
        .error_event(error_event),
        .error_flag(flash_error_flag)
    );

    flash_power_state u_pwr (
        .aclk(aclk),
        .aresetn(aresetn),
        .chip_mode(chip_mode),
        .low_power_select(flash_low_power_select),
        .flash_state(flash_state)
    );

    // ---- Checks ----
    AST_NO_UNLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        !software_write_unlock_bit |=> !program_pulse && erase_pulse == '0)
        else $error("program or erase without unlock");

    AST_IRQ_MASK: assert property (@(posedge aclk) disable iff (!aresetn)
        (program_pulse || erase_pulse != '0 || boot_running) |-> irq_disable)
        else $error("interrupts open during operation");

    AST_HW_CLEAR: assert property (@(posedge aclk) disable iff (!aresetn)
        hw_protect |=> flash_ctrl_reg_first == RST_BYTE && erase_block_select_reg == '0
        ##1 !program_pulse && erase_pulse == '0)
        else $error("low-power entry did not clear");

    AST_ERASE_BLOCK: assert property (@(posedge aclk) disable iff (!aresetn)
        erase_pulse != '0 |-> erase_pulse == $past(erase_block_select_reg))
        else $error("erase on unselected block");

    AST_ERASE_TRACK: assert property (@(posedge aclk) disable iff (!aresetn)
        erase_pulse != '0 |-> $past(flash_ctrl_reg_first[BIT_ERASE]))
        else $error("erase without erase bit");

    AST_ERR_REFUSE: assert property (@(posedge aclk) disable iff (!aresetn)
        flash_error_flag |=> !program_pulse && erase_pulse == '0)
        else $error("operation re-entered after error");

    AST_ERR_VERIFY: assert property (@(posedge aclk) disable iff (!aresetn)
        (flash_error_flag && software_write_unlock_bit && !hw_protect && write_check_bit)
        |=> program_verify)
        else $error("verify blocked by error");

    AST_MULTI_NONE: assert property (@(posedge aclk) disable iff (!aresetn)
        !is_onehot(erase_block_select_reg) |=> erase_pulse == '0)
        else $error("erase with bad block selection");

    AST_BVALID_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

endmodule : flash_erase_protect_ctrl

// ### core/flash_epc_pkg.sv
// Purpose: Shared constants for the flash erase/protect controller
// Assumes: 32-bit AXI4-Lite register bus, one clock
// Notes: Register offsets are byte addresses
// Contract
// - Erase runs exactly while erase bit set
// - Dummy FF byte write arms verify reads
// - Erase needs no prior zero prewrite
// - Interrupts masked during program, erase, boot
// - Low-power or reset entry aborts, clears registers
// - Without unlock bit, no program or erase
// - Unselected blocks protected; zero protects all
// - Algorithm error sets flag, enters protection
// - Reading flash during operation is an error
// - Non-reset exception during operation is error
// - Sleep during operation is an error
// - On error keep registers, abort, refuse re-entry
// - Verify modes remain usable under error
// - Error state cleared only by reset
// - Subactive uses power-down unless select bit set
// - Subsleep and standby halt the flash
// - First control register picks four modes
// - Program runs exactly while program bit set
package flash_epc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL1 = 8'h00;
    localparam logic [7:0] OFS_CTRL2 = 8'h04;
    localparam logic [7:0] OFS_BLKSEL = 8'h08;
    localparam logic [7:0] OFS_PWR = 8'h0c;
    localparam logic [7:0] OFS_VDUMMY = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // First control register fields
    localparam int BIT_PROG = 0;
    localparam int BIT_ERASE = 1;
    localparam int BIT_WCHK = 2;
    localparam int BIT_ECHK = 3;
    localparam int BIT_UNLOCK = 6;
    localparam logic [7:0] CTRL1_MASK = 8'h4f;
    // Second control and power register fields
    localparam int BIT_ERR = 7;
    localparam int BIT_LPSEL = 7;

    // Reset values and the verify dummy pattern
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] VDUMMY_DATA = 8'hff;
    localparam logic [3:0] VDUMMY_STRB = 4'h1;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        MODE_IDLE = 3'b000,
        MODE_PROG = 3'b001,
        MODE_PVER = 3'b010,
        MODE_ERASE = 3'b011,
        MODE_EVER = 3'b100
    } mode_t;

    typedef enum logic [2:0] {
        CM_ACTIVE = 3'b000,
        CM_SLEEP = 3'b001,
        CM_SUBACTIVE = 3'b010,
        CM_SUBSLEEP = 3'b011,
        CM_STANDBY = 3'b100
    } cmode_t;

    typedef enum logic [1:0] {
        PS_NORMAL = 2'b00,
        PS_POWERDOWN = 2'b01,
        PS_STANDBY = 2'b10
    } pstate_t;

endpackage : flash_epc_pkg

// ### core/flash_power_state.sv
// Purpose: Flash power state from chip operating mode
// Assumes: chip_mode comes from logic on aclk
// Notes: Output registered, one cycle behind mode
module flash_power_state
    import flash_epc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire cmode_t chip_mode,
    input wire logic low_power_select,
    output pstate_t flash_state
);

    // Decode chip mode into flash state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flash_state <= PS_NORMAL;
        end else begin
            case (chip_mode)
                CM_SUBACTIVE: flash_state <= low_power_select ? PS_NORMAL : PS_POWERDOWN;
                CM_SUBSLEEP, CM_STANDBY: flash_state <= PS_STANDBY;
                default: flash_state <= PS_NORMAL;
            endcase
        end
    end

    AST_HALT_IN_STANDBY: assert property (@(posedge aclk) disable iff (!aresetn)
        (chip_mode == CM_STANDBY || chip_mode == CM_SUBSLEEP) |=> flash_state == PS_STANDBY)
        else $error("flash not halted in standby");

endmodule : flash_power_state

// ### core/flash_error_latch.sv
// Purpose: Sticky error detection during program or erase
// Assumes: Event inputs are same-clock single-cycle or level
// Notes: Only reset clears the flag
module flash_error_latch (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic busy,
    input wire logic flash_area_read,
    input wire logic exception_start,
    input wire logic sleep_exec,
    output logic error_event,
    output logic error_flag
);

    // Error sources while programming or erasing
    assign error_event = busy && (flash_area_read || exception_start || sleep_exec);

    // Nothing but reset clears it; no software clear exists
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            error_flag <= 1'b0;
        end else if (error_event) begin
            error_flag <= 1'b1;
        end
    end

    AST_ERR_STICKY: assert property (@(posedge aclk) disable iff (!aresetn)
        error_flag |=> error_flag)
        else $error("error flag cleared without reset");

    AST_ERR_SET: assert property (@(posedge aclk) disable iff (!aresetn)
        (busy && sleep_exec) |=> error_flag)
        else $error("sleep during operation not flagged");

endmodule : flash_error_latch

// ### tb/flash_erase_protect_ctrl_tb_top.sv
// Purpose: Self-checking bench for the flash erase/protect controller
// Assumes: AXI4-Lite master tasks, inputs driven by NBA at rising edge
// Notes: Outputs sampled at the falling edge so edge updates have landed
module flash_erase_protect_ctrl_tb_top
    import flash_epc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    cmode_t chip_mode;
    logic boot_running, flash_area_read, exception_start, sleep_exec;
    logic program_pulse, program_verify, erase_verify, verify_read_enable, irq_disable;
    logic [7:0] erase_pulse;
    pstate_t flash_state, exp_ps;
    int n_fail, checks_done, cycles;

    flash_erase_protect_ctrl #(.NUM_BLOCKS(8)) uut (
        .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .chip_mode(chip_mode), .boot_running(boot_running),
        .flash_area_read(flash_area_read), .exception_start(exception_start),
        .sleep_exec(sleep_exec), .program_pulse(program_pulse), .erase_pulse(erase_pulse),
        .program_verify(program_verify), .erase_verify(erase_verify),
        .verify_read_enable(verify_read_enable), .irq_disable(irq_disable),
        .flash_state(flash_state)
    );

    // Free-running 50 MHz clock
    initial aclk = 1'b0;
    always #10 aclk = ~aclk;

    // Hang guard, well above the few thousand cycles the tests need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("BAD %0t timeout", $time);
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    // Compare of a port value
    task automatic chk_sig(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_sig

    // Compare of a bus answer, data and response together
    task automatic chk_reg(input logic [31:0] d, input logic [1:0] r,
                           input logic [31:0] ed, input logic [1:0] er, input logic [7:0] a);
        checks_done++;
        if (d !== ed || r !== er) begin
            n_fail++;
            $display("BAD %0t addr %h got %h/%h exp %h/%h", $time, a, d, r, ed, er);
        end
    endtask : chk_reg

    // Let n edges pass, then sample where outputs have settled
    task automatic wait_n(input int n);
        repeat (n) @(posedge aclk);
        @(negedge aclk);
    endtask : wait_n

    // Write with both halves offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        logic aw_ok, w_ok, b_ok;
        logic [1:0] r;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        b_ok = 1'b0;
        while (!b_ok) begin
            @(negedge aclk);
            aw_ok = awvalid && awready;
            w_ok = wvalid && wready;
            b_ok = bvalid;
            r = bresp;
            @(posedge aclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk_reg(32'h0, r, 32'h0, er, a);
    endtask : wr

    // Read and compare; rready held until rvalid is seen
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ar_ok, r_ok;
        logic [31:0] d;
        logic [1:0] r;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        r_ok = 1'b0;
        while (!r_ok) begin
            @(negedge aclk);
            ar_ok = arvalid && arready;
            r_ok = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ar_ok) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        chk_reg(d, r, ed, er, a);
    endtask : rd

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        chip_mode <= CM_ACTIVE;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask : do_reset

    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb, awprot, arprot} = '0;
        {boot_running, flash_area_read, exception_start, sleep_exec} = '0;
        chip_mode = CM_ACTIVE;
        n_fail = 0;
        checks_done = 0;
        cycles = 0;
        do_reset();
        // Reset values, unmapped and read-only places
        rd(OFS_CTRL1, 32'h0, AXI_OKAY);
        rd(OFS_BLKSEL, 32'h0, AXI_OKAY);
        rd(OFS_PWR, 32'h0, AXI_OKAY);
        rd(OFS_STATUS, 32'h0, AXI_OKAY);
        rd(8'h18, 32'h0, AXI_SLVERR);
        wr(8'h18, 32'hff, 4'hf, AXI_SLVERR);
        wr(OFS_STATUS, 32'hff, 4'hf, AXI_SLVERR);
        // Software protection: enables without unlock do nothing
        wr(OFS_BLKSEL, 32'h01, 4'h1, AXI_OKAY);
        wr(OFS_CTRL1, 32'h03, 4'h1, AXI_OKAY);
        wait_n(2);
        chk_sig(program_pulse, 1'b0, "locked program");
        chk_sig(erase_pulse, 8'h00, "locked erase");
        // Program runs exactly while its bit is set
        wr(OFS_CTRL1, 32'h41, 4'h1, AXI_OKAY);
        wait_n(2);
        chk_sig(program_pulse, 1'b1, "program on");
        chk_sig(irq_disable, 1'b1, "irq masked in program");
        rd(OFS_STATUS, 32'h41, AXI_OKAY);
        wr(OFS_CTRL1, 32'h44, 4'h1, AXI_OKAY);
        wait_n(2);
        chk_sig(program_pulse, 1'b0, "program off");
        chk_sig(program_verify, 1'b1, "program verify");
        chk_sig(irq_disable, 1'b0, "irq free in verify");
        // Verify arming needs exactly one FF byte
        wr(OFS_VDUMMY, 32'h7f, VDUMMY_STRB, AXI_OKAY);
        wait_n(2);
        chk_sig(verify_read_enable, 1'b0, "bad dummy");
        wr(OFS_VDUMMY, {24'h0, VDUMMY_DATA}, VDUMMY_STRB, AXI_OKAY);
        wait_n(2);
        chk_sig(verify_read_enable, 1'b1, "dummy armed");
        rd(OFS_STATUS, 32'h22, AXI_OKAY);
        // Erase with zero, several and one selected block
        wr(OFS_BLKSEL, 32'h00, 4'h1, AXI_OKAY);
        wr(OFS_CTRL1, 32'h42, 4'h1, AXI_OKAY);
        wait_n(2);
        chk_sig(erase_pulse, 8'h00, "zero select");
        wr(OFS_BLKSEL, 32'h05, 4'h1, AXI_OKAY);
        wait_n(2);
        chk_sig(erase_pulse, 8'h00, "multi select");
        wr(OFS_BLKSEL, 32'h80, 4'h1, AXI_OKAY);
        wait_n(2);
        chk_sig(erase_pulse, 8'h80, "single block erase");
        rd(OFS_STATUS, 32'h43, AXI_OKAY);
        wr(OFS_CTRL1, 32'h48, 4'h1, AXI_OKAY);
        wait_n(2);
        chk_sig(erase_pulse, 8'h00, "erase off");
        chk_sig(erase_verify, 1'b1, "erase verify");
        // Unerased block: retry erase and erase verify twice
        for (int n = 0; n < 2; n++) begin
            wr(OFS_CTRL1, 32'h42, 4'h1, AXI_OKAY);
            wait_n(2);
            chk_sig(erase_pulse, 8'h80, "erase retry");
            wr(OFS_CTRL1, 32'h48, 4'h1, AXI_OKAY);
            wait_n(2);
            chk_sig(erase_verify, 1'b1, "verify retry");
        end
        // Boot program masks interrupts on its own
        @(posedge aclk);
        boot_running <= 1'b1;
        wait_n(1);
        chk_sig(irq_disable, 1'b1, "boot mask");
        @(posedge aclk);
        boot_running <= 1'b0;
        // Low-power entry aborts erase and clears the registers
        for (int m = 2; m <= 4; m++) begin
            wr(OFS_BLKSEL, 32'h01, 4'h1, AXI_OKAY);
            wr(OFS_CTRL1, 32'h42, 4'h1, AXI_OKAY);
            wait_n(2);
            chk_sig(erase_pulse, 8'h01, "erase before low power");
            @(posedge aclk);
            chip_mode <= cmode_t'(m[2:0]);
            wait_n(2);
            chk_sig(erase_pulse, 8'h00, "erase aborted");
            @(posedge aclk);
            chip_mode <= CM_ACTIVE;
            // Over 20 us of settling before the flash is used again
            wait_n(1000);
            rd(OFS_CTRL1, 32'h0, AXI_OKAY);
            rd(OFS_BLKSEL, 32'h0, AXI_OKAY);
        end
        // Flash power state for every chip mode and both select values
        for (int lp = 0; lp < 2; lp++) begin
            @(posedge aclk);
            chip_mode <= CM_ACTIVE;
            wr(OFS_PWR, lp * 32'h80, 4'h1, AXI_OKAY);
            for (int m = 0; m <= 4; m++) begin
                @(posedge aclk);
                chip_mode <= cmode_t'(m[2:0]);
                wait_n(3);
                exp_ps = (m >= 3) ? PS_STANDBY : (m == 2 && lp == 0) ? PS_POWERDOWN : PS_NORMAL;
                chk_sig(32'(flash_state), 32'(exp_ps), "flash state");
            end
        end
        // Each error source, from a fresh reset since the flag is sticky
        for (int k = 0; k < 3; k++) begin
            do_reset();
            wait_n(1);
            chk_sig(erase_verify, 1'b0, "reset clears verify");
            rd(OFS_CTRL2, 32'h0, AXI_OKAY);
            rd(OFS_CTRL1, 32'h0, AXI_OKAY);
            wr(OFS_BLKSEL, 32'h02, 4'h1, AXI_OKAY);
            wr(OFS_CTRL1, 32'h42, 4'h1, AXI_OKAY);
            wait_n(2);
            chk_sig(erase_pulse, 8'h02, "erase before error");
            @(posedge aclk);
            flash_area_read <= (k == 0);
            exception_start <= (k == 1);
            sleep_exec <= (k == 2);
            @(posedge aclk);
            {flash_area_read, exception_start, sleep_exec} <= '0;
            wait_n(1);
            chk_sig(erase_pulse, 8'h00, "error aborts");
            rd(OFS_CTRL2, 32'h80, AXI_OKAY);
            rd(OFS_CTRL1, 32'h42, AXI_OKAY);
            rd(OFS_BLKSEL, 32'h02, AXI_OKAY);
            wr(OFS_CTRL1, 32'h40, 4'h1, AXI_OKAY);
            wr(OFS_CTRL1, 32'h42, 4'h1, AXI_OKAY);
            wait_n(2);
            chk_sig(erase_pulse, 8'h00, "re-entry refused");
            wr(OFS_CTRL1, 32'h48, 4'h1, AXI_OKAY);
            wait_n(2);
            chk_sig(erase_verify, 1'b1, "verify under error");
            wr(OFS_CTRL1, 32'h44, 4'h1, AXI_OKAY);
            wait_n(2);
            chk_sig(program_verify, 1'b1, "write check under error");
            wr(OFS_CTRL2, 32'h00, 4'h1, AXI_OKAY);
            rd(OFS_CTRL2, 32'h80, AXI_OKAY);
        end
        stop_test();
    end

endmodule : flash_erase_protect_ctrl_tb_top
